// [ccdo_core.sv]
// Execution of watchdog clear, call via working, complement, clear and decrement operations
`timescale 1ns/100ps
module ccdo_core #(
  parameter int unsigned STACK_DEPTH = ccdo_pkg::STACK_DEPTH,
  parameter int unsigned PRESCALE    = ccdo_pkg::WDT_PRESCALE
) (
  input  wire logic        clk,       // 200 MHz core clock
  input  wire logic        rst_b,     // Sync reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write not read
  input  wire logic [2:0]  hsize,     // Word only
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Slave ready
  output logic [31:0]      hrdata,    // Read data
  output logic             hresp      // Always OKAY
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);
  localparam int unsigned PS_W = $clog2(PRESCALE);

  // Bus state
  logic        dph_valid, next_dph_valid;
  logic        dph_write, next_dph_write;
  logic [7:0]  dph_addr,  next_dph_addr;
  logic        next_hreadyout;
  logic [31:0] next_hrdata;
  logic        next_hresp;
  logic        wr_strobe;
  logic [31:0] rd_word;

  // Core state
  ccdo_pkg::ccdo_state_e state, next_state;
  logic [7:0]  working_reg, next_working_reg;
  logic        zero_flag, next_zero_flag;
  logic        timeout_flag, next_timeout_flag;
  logic        powerdown_flag, next_powerdown_flag;
  logic [14:0] pc, next_pc;
  logic [6:0]  pc_high_latch, next_pc_high_latch;
  logic        skip_pending, next_skip_pending;
  logic [6:0]  faddr, next_faddr;
  logic [14:0] stack [STACK_DEPTH];
  logic [14:0] next_stack [STACK_DEPTH];
  logic [SP_W-1:0] sp, next_sp;
  logic [14:0] stack_top;

  // Execution decode
  logic        ex_go, ex_run, squash, busy, ex_dest, f_we, wdt_clear, wdt_expire;
  logic [3:0]  ex_op;
  logic [6:0]  ex_addr, f_waddr;
  logic [7:0]  file_rd, bus_file_rd, dec_val, result, f_wdata, wdt_count;
  logic [PS_W-1:0] wdt_prescale;

  ccdo_file_regs #(
    .DEPTH   (ccdo_pkg::FILE_DEPTH),
    .WIDTH   (8)
  ) u_file (
    .clk     (clk),
    .rst_b   (rst_b),
    .we      (f_we),
    .waddr   (f_waddr),
    .wdata   (f_wdata),
    .raddr_a (ex_addr),
    .rdata_a (file_rd),
    .raddr_b (faddr),
    .rdata_b (bus_file_rd)
  );
  ccdo_watchdog #(
    .PRESCALE (PRESCALE),
    .CNT_W    (8)
  ) u_wdt (
    .clk      (clk),
    .rst_b    (rst_b),
    .clear    (wdt_clear),
    .count    (wdt_count),
    .prescale (wdt_prescale),
    .expire   (wdt_expire)
  );
  // AHB-Lite slave: writes take no wait state, reads take one so hrdata is a flop
  always_comb begin
    next_dph_valid = dph_valid;
    next_dph_write = dph_write;
    next_dph_addr  = dph_addr;
    next_hreadyout = hreadyout;
    next_hrdata    = hrdata;
    next_hresp     = 1'b0;
    wr_strobe      = dph_valid && dph_write && hready;
    rd_word        = '0;
    case (dph_addr)
      ccdo_pkg::WORK_OFS:  rd_word[7:0] = working_reg;
      ccdo_pkg::STAT_OFS: begin
        rd_word[ccdo_pkg::ST_ZERO_BIT]    = zero_flag;
        rd_word[ccdo_pkg::ST_TIMEOUT_BIT] = timeout_flag;
        rd_word[ccdo_pkg::ST_PD_BIT]      = powerdown_flag;
        rd_word[ccdo_pkg::ST_BUSY_BIT]    = busy;
        rd_word[ccdo_pkg::ST_SKIP_BIT]    = skip_pending;
      end
      ccdo_pkg::PC_OFS: begin
        rd_word[14:0] = pc;
        rd_word[ccdo_pkg::PC_PLH_LSB +: 7] = pc_high_latch;
      end
      ccdo_pkg::STACK_OFS: begin
        rd_word[14:0] = stack_top;
        rd_word[ccdo_pkg::STACK_PTR_LSB +: SP_W] = sp;
      end
      ccdo_pkg::FADDR_OFS: rd_word[6:0] = faddr;
      ccdo_pkg::FDATA_OFS: rd_word[7:0] = bus_file_rd;
      ccdo_pkg::WDT_OFS:   rd_word[7:0] = wdt_count;
      default:             rd_word = '0;
    endcase
    if (dph_valid && !dph_write && !hreadyout) begin
      next_hrdata    = rd_word;
      next_hreadyout = 1'b1;
      next_dph_valid = 1'b0;
    end else if (hready) begin
      next_dph_valid = hsel && htrans[1];
      next_dph_write = hwrite;
      next_dph_addr  = haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        next_hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= '0;
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= 1'b0;
    end else begin
      dph_valid <= next_dph_valid;
      dph_write <= next_dph_write;
      dph_addr  <= next_dph_addr;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
      hresp     <= next_hresp;
    end
  end

  // Execution: an EXEC write while busy is dropped, since the flush slot owns that cycle
  always_comb begin
    busy      = (state == ccdo_pkg::CCDO_FLUSH);
    ex_go     = wr_strobe && (dph_addr == ccdo_pkg::EXEC_OFS) && !busy;
    squash    = ex_go && skip_pending;
    ex_run    = ex_go && !skip_pending;
    ex_op     = hwdata[ccdo_pkg::EXEC_OP_LSB +: 4];
    ex_dest   = hwdata[ccdo_pkg::EXEC_DEST_BIT];
    ex_addr   = hwdata[ccdo_pkg::EXEC_FADDR_LSB +: 7];
    stack_top = stack[SP_W'(sp - 1'b1)];
    dec_val   = file_rd - ccdo_pkg::DEC_STEP;
    result    = dec_val;
    next_state          = ccdo_pkg::CCDO_IDLE;
    next_working_reg    = working_reg;
    next_zero_flag      = zero_flag;
    next_timeout_flag   = timeout_flag;
    next_powerdown_flag = powerdown_flag;
    next_pc             = pc;
    next_pc_high_latch  = pc_high_latch;
    next_skip_pending   = skip_pending;
    next_faddr          = faddr;
    next_stack          = stack;
    next_sp             = sp;
    f_we      = 1'b0;
    f_waddr   = ex_addr;
    f_wdata   = result;
    wdt_clear = 1'b0;
    if (wdt_expire) begin
      next_timeout_flag = 1'b0;
    end
    if (squash) begin
      next_pc           = pc + ccdo_pkg::PC_STEP;
      next_skip_pending = 1'b0;
    end
    if (ex_run) begin
      next_pc = pc + ccdo_pkg::PC_STEP;
      case (ex_op)
        ccdo_pkg::OP_CLR_WDT: begin
          wdt_clear           = 1'b1;
          next_timeout_flag   = 1'b1;
          next_powerdown_flag = 1'b1;
        end
        ccdo_pkg::OP_CALL_W: begin
          next_stack[sp] = pc + ccdo_pkg::PC_STEP;
          next_sp        = SP_W'(sp + 1'b1);
          next_pc        = {pc_high_latch, working_reg};
          next_state     = ccdo_pkg::CCDO_FLUSH;
        end
        ccdo_pkg::OP_COMP_F, ccdo_pkg::OP_DEC_F, ccdo_pkg::OP_DEC_SKIP: begin
          result = (ex_op == ccdo_pkg::OP_COMP_F) ? ~file_rd : dec_val;
          f_wdata = result;
          if (ex_dest == ccdo_pkg::DEST_WORKING) begin
            next_working_reg = result;
          end else begin
            f_we = 1'b1;
          end
          if (ex_op == ccdo_pkg::OP_DEC_SKIP) begin
            next_skip_pending = (result == ccdo_pkg::CLEAR_VAL);
          end else begin
            next_zero_flag = (result == ccdo_pkg::CLEAR_VAL);
          end
        end
        ccdo_pkg::OP_CLR_F: begin
          f_we           = 1'b1;
          f_wdata        = ccdo_pkg::CLEAR_VAL;
          next_zero_flag = 1'b1;
        end
        ccdo_pkg::OP_CLR_W: begin
          next_working_reg = ccdo_pkg::CLEAR_VAL;
          next_zero_flag   = 1'b1;
        end
        default: next_pc = pc + ccdo_pkg::PC_STEP;
      endcase
    end
    if (wr_strobe && !busy) begin
      case (dph_addr)
        ccdo_pkg::WORK_OFS: next_working_reg = hwdata[7:0];
        ccdo_pkg::PC_OFS: begin
          next_pc            = hwdata[14:0];
          next_pc_high_latch = hwdata[ccdo_pkg::PC_PLH_LSB +: 7];
        end
        ccdo_pkg::FADDR_OFS: next_faddr = hwdata[6:0];
        ccdo_pkg::FDATA_OFS: begin
          f_we    = 1'b1;
          f_waddr = faddr;
          f_wdata = hwdata[7:0];
        end
        default: next_faddr = faddr;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state          <= ccdo_pkg::CCDO_IDLE;
      working_reg    <= ccdo_pkg::WORK_RST;
      zero_flag      <= 1'b0;
      timeout_flag   <= ccdo_pkg::TIMEOUT_RST;
      powerdown_flag <= ccdo_pkg::PD_RST;
      pc             <= ccdo_pkg::PC_RST;
      pc_high_latch  <= ccdo_pkg::PLH_RST;
      skip_pending   <= 1'b0;
      faddr          <= ccdo_pkg::FADDR_RST;
      sp             <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= '0;
      end
    end else begin
      state          <= next_state;
      working_reg    <= next_working_reg;
      zero_flag      <= next_zero_flag;
      timeout_flag   <= next_timeout_flag;
      powerdown_flag <= next_powerdown_flag;
      pc             <= next_pc;
      pc_high_latch  <= next_pc_high_latch;
      skip_pending   <= next_skip_pending;
      faddr          <= next_faddr;
      sp             <= next_sp;
      stack          <= next_stack;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence call_issue_s;
    ex_run && (ex_op == ccdo_pkg::OP_CALL_W);
  endsequence
  sequence flush_then_free_s;
    busy ##1 !busy;
  endsequence
  wdt_clear_flags_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_CLR_WDT |=> timeout_flag && powerdown_flag
      && wdt_count == ccdo_pkg::WDT_CLEAR_VAL && zero_flag == $past(zero_flag))
    else $error("watchdog clear did not load counter and flags");
  wdt_prescale_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_CLR_WDT |=> wdt_prescale == '0)
    else $error("watchdog clear left prescaler running");
  call_push_a: assert property (
    call_issue_s |=> stack_top == $past(pc) + ccdo_pkg::PC_STEP && sp == $past(sp) + 1'b1)
    else $error("call did not push return address");
  call_target_a: assert property (
    call_issue_s |=> pc == {$past(pc_high_latch), $past(working_reg)}
      && zero_flag == $past(zero_flag))
    else $error("call loaded wrong target");
  call_flush_a: assert property (
    call_issue_s |=> flush_then_free_s)
    else $error("call did not take two cycles");
  comp_result_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_COMP_F && ex_dest == ccdo_pkg::DEST_WORKING
      |=> working_reg == ~$past(file_rd) && zero_flag == (working_reg == 8'h00))
    else $error("complement result or zero wrong");
  dest_file_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_DEC_F && ex_dest == ccdo_pkg::DEST_FILE
      |-> f_we && f_waddr == ex_addr ##1 working_reg == $past(working_reg))
    else $error("file destination touched working register");
  clr_file_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_CLR_F |-> f_we && f_wdata == 8'h00 ##1 zero_flag)
    else $error("clear file did not clear or set zero");
  dec_result_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_DEC_F && ex_dest == ccdo_pkg::DEST_WORKING
      |=> working_reg == $past(file_rd) - 8'h01)
    else $error("decrement result wrong");
  clr_work_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_CLR_W |=> working_reg == 8'h00 && zero_flag)
    else $error("clear working failed");
  skip_status_a: assert property (
    ex_run && ex_op == ccdo_pkg::OP_DEC_SKIP |=> $stable(zero_flag)
      && $stable(timeout_flag) && skip_pending == ($past(file_rd) == 8'h01))
    else $error("decrement-skip changed status or skip wrong");
  skip_squash_a: assert property (
    squash |-> !f_we && !wdt_clear ##1 !skip_pending && $stable(working_reg))
    else $error("skipped instruction was executed");
  single_cycle_a: assert property (
    ex_run && ex_op != ccdo_pkg::OP_CALL_W |=> !busy)
    else $error("single-cycle operation stalled");
endmodule

// [ccdo_core_test.sv]
// Self-checking bench for the clear/complement/decrement execution block
`timescale 1ns/100ps
module ccdo_core_test;
  // Short prescale keeps the watchdog overflow within a brief run
  localparam int unsigned PS = 4;

  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  int          err_count;
  int          cmp_count;
  logic [14:0] epc;
  logic [31:0] rv;

  ccdo_core #(.STACK_DEPTH(16), .PRESCALE(PS)) u_dut (
    .clk       (clk),
    .rst_b     (rst_b),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp)
  );

  // Only one slave on the bus
  assign hready = hreadyout;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Returns right after the edge at which ready was sampled high
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        $display("[ERR] bus ready expected 1 seen stuck");
        summarize();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    check(name, r, exp);
  endtask

  task automatic setf(input logic [6:0] a, input logic [7:0] d);
    wr(ccdo_pkg::FADDR_OFS, {25'h0000000, a});
    wr(ccdo_pkg::FDATA_OFS, {24'h000000, d});
  endtask

  task automatic exec(input logic [3:0] op, input logic dest, input logic [6:0] fa);
    wr(ccdo_pkg::EXEC_OFS, {17'h00000, fa, 3'h0, dest, op});
    epc = epc + ccdo_pkg::PC_STEP;
  endtask

  function automatic logic [31:0] st(input logic z, input logic to, input logic pd,
                                     input logic sk);
    return {27'h0000000, sk, 1'b0, pd, to, z};
  endfunction

  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_b     = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h00000000;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h00000000;
    epc       = 15'h0000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b0, 1'b1, 1'b1, 1'b0));
    expect_reg("unmapped", 8'h40, 32'h00000000);
    check("hresp", {31'h00000000, hresp}, 32'h00000000);
    // Clear file from a nonzero value
    setf(7'h05, 8'h3c);
    exec(ccdo_pkg::OP_CLR_F, ccdo_pkg::DEST_FILE, 7'h05);
    expect_reg("file05", ccdo_pkg::FDATA_OFS, 32'h00000000);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b1, 1'b1, 1'b0));
    // Complement into working, then back into the top file address
    wr(ccdo_pkg::WORK_OFS, 32'h00000011);
    setf(7'h7f, 8'h5a);
    exec(ccdo_pkg::OP_COMP_F, ccdo_pkg::DEST_WORKING, 7'h7f);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h000000a5);
    expect_reg("file7f", ccdo_pkg::FDATA_OFS, 32'h0000005a);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b0, 1'b1, 1'b1, 1'b0));
    exec(ccdo_pkg::OP_COMP_F, ccdo_pkg::DEST_FILE, 7'h7f);
    expect_reg("file7f", ccdo_pkg::FDATA_OFS, 32'h000000a5);
    setf(7'h00, 8'hff);
    exec(ccdo_pkg::OP_COMP_F, ccdo_pkg::DEST_FILE, 7'h00);
    expect_reg("file00", ccdo_pkg::FDATA_OFS, 32'h00000000);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b1, 1'b1, 1'b0));
    // Decrement wraps from zero; then down to zero
    setf(7'h03, 8'h00);
    exec(ccdo_pkg::OP_DEC_F, ccdo_pkg::DEST_WORKING, 7'h03);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h000000ff);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b0, 1'b1, 1'b1, 1'b0));
    setf(7'h03, 8'h01);
    exec(ccdo_pkg::OP_DEC_F, ccdo_pkg::DEST_FILE, 7'h03);
    expect_reg("file03", ccdo_pkg::FDATA_OFS, 32'h00000000);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b1, 1'b1, 1'b0));
    // Back to back: each op sees the previous write
    setf(7'h0a, 8'h10);
    exec(ccdo_pkg::OP_DEC_F, ccdo_pkg::DEST_FILE, 7'h0a);
    exec(ccdo_pkg::OP_DEC_F, ccdo_pkg::DEST_FILE, 7'h0a);
    exec(ccdo_pkg::OP_COMP_F, ccdo_pkg::DEST_WORKING, 7'h0a);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h000000f1);
    // Clear working
    wr(ccdo_pkg::WORK_OFS, 32'h00000077);
    exec(ccdo_pkg::OP_CLR_W, ccdo_pkg::DEST_WORKING, 7'h00);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h00000000);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b1, 1'b1, 1'b0));
    // Idle codes only advance the program counter
    exec(ccdo_pkg::OP_IDLE_SLOT, ccdo_pkg::DEST_FILE, 7'h0a);
    exec(4'hf, ccdo_pkg::DEST_FILE, 7'h0a);
    expect_reg("file0a", ccdo_pkg::FDATA_OFS, 32'h0000000e);
    expect_reg("pc", ccdo_pkg::PC_OFS, {17'h00000, epc});
    // Skip on zero with zero flag held low beforehand
    exec(ccdo_pkg::OP_COMP_F, ccdo_pkg::DEST_WORKING, 7'h0a);
    setf(7'h09, 8'h02);
    exec(ccdo_pkg::OP_DEC_SKIP, ccdo_pkg::DEST_FILE, 7'h09);
    expect_reg("file09", ccdo_pkg::FDATA_OFS, 32'h00000001);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b0, 1'b1, 1'b1, 1'b0));
    exec(ccdo_pkg::OP_DEC_SKIP, ccdo_pkg::DEST_WORKING, 7'h09);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h00000000);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b0, 1'b1, 1'b1, 1'b1));
    wr(ccdo_pkg::WORK_OFS, 32'h00000055);
    exec(ccdo_pkg::OP_CLR_W, ccdo_pkg::DEST_WORKING, 7'h00);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h00000055);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b0, 1'b1, 1'b1, 1'b0));
    expect_reg("pc", ccdo_pkg::PC_OFS, {17'h00000, epc});
    exec(ccdo_pkg::OP_CLR_W, ccdo_pkg::DEST_WORKING, 7'h00);
    expect_reg("work", ccdo_pkg::WORK_OFS, 32'h00000000);
    // Let the watchdog overflow, then clear it
    exec(ccdo_pkg::OP_CLR_WDT, ccdo_pkg::DEST_WORKING, 7'h00);
    repeat (256 * PS + 64) @(posedge clk);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b0, 1'b1, 1'b0));
    exec(ccdo_pkg::OP_CLR_WDT, ccdo_pkg::DEST_WORKING, 7'h00);
    expect_reg("wdt", ccdo_pkg::WDT_OFS, 32'h00000000);
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b1, 1'b1, 1'b0));
    // Call via working with a nonzero high latch
    wr(ccdo_pkg::PC_OFS, {9'h000, 7'h5a, 1'b0, 15'h1234});
    wr(ccdo_pkg::WORK_OFS, 32'h000000c3);
    exec(ccdo_pkg::OP_CALL_W, ccdo_pkg::DEST_WORKING, 7'h00);
    epc = 15'h5ac3;
    expect_reg("pc", ccdo_pkg::PC_OFS, {9'h000, 7'h5a, 1'b0, epc});
    expect_reg("stack", ccdo_pkg::STACK_OFS, {12'h000, 4'h1, 1'b0, 15'h1235});
    expect_reg("status", ccdo_pkg::STAT_OFS, st(1'b1, 1'b1, 1'b1, 1'b0));
    exec(ccdo_pkg::OP_IDLE_SLOT, ccdo_pkg::DEST_WORKING, 7'h00);
    expect_reg("pc", ccdo_pkg::PC_OFS, {9'h000, 7'h5a, 1'b0, epc});
    summarize();
  end
endmodule

// [ccdo_file_regs.sv]
// File register storage: one write port, two read ports
`timescale 1ns/100ps
module ccdo_file_regs #(
  parameter int unsigned DEPTH  = ccdo_pkg::FILE_DEPTH,
  parameter int unsigned WIDTH  = 8,
  parameter int unsigned AW     = $clog2(DEPTH)
) (
  input  wire logic             clk,     // Core clock
  input  wire logic             rst_b,   // Sync reset, active low
  input  wire logic             we,      // Write strobe
  input  wire logic [AW-1:0]    waddr,   // Write address
  input  wire logic [WIDTH-1:0] wdata,   // Write data
  input  wire logic [AW-1:0]    raddr_a, // Execution read address
  output logic [WIDTH-1:0]      rdata_a, // Execution read data
  input  wire logic [AW-1:0]    raddr_b, // Bus read address
  output logic [WIDTH-1:0]      rdata_b  // Bus read data
);
  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];

  always_comb begin
    next_mem = mem;
    if (we) begin
      next_mem[waddr] = wdata;
    end
    rdata_a = mem[raddr_a];
    rdata_b = mem[raddr_b];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem <= next_mem;
    end
  end
endmodule

// [ccdo_pkg.sv]
// Constants, opcodes and register map for the clear/complement/decrement execution block
package ccdo_pkg;

  // Register byte offsets
  localparam logic [7:0] EXEC_OFS  = 8'h00;
  localparam logic [7:0] WORK_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] PC_OFS    = 8'h0c;
  localparam logic [7:0] STACK_OFS = 8'h10;
  localparam logic [7:0] FADDR_OFS = 8'h14;
  localparam logic [7:0] FDATA_OFS = 8'h18;
  localparam logic [7:0] WDT_OFS   = 8'h1c;

  // Field positions
  localparam int unsigned EXEC_OP_LSB    = 0;
  localparam int unsigned EXEC_DEST_BIT  = 4;
  localparam int unsigned EXEC_FADDR_LSB = 8;
  localparam int unsigned ST_ZERO_BIT    = 0;
  localparam int unsigned ST_TIMEOUT_BIT = 1;
  localparam int unsigned ST_PD_BIT      = 2;
  localparam int unsigned ST_BUSY_BIT    = 3;
  localparam int unsigned ST_SKIP_BIT    = 4;
  localparam int unsigned PC_PLH_LSB     = 16;
  localparam int unsigned STACK_PTR_LSB  = 16;

  // Operation codes
  localparam logic [3:0] OP_IDLE_SLOT = 4'h0;
  localparam logic [3:0] OP_CLR_WDT   = 4'h1;
  localparam logic [3:0] OP_CALL_W    = 4'h2;
  localparam logic [3:0] OP_COMP_F    = 4'h3;
  localparam logic [3:0] OP_CLR_F     = 4'h4;
  localparam logic [3:0] OP_DEC_F     = 4'h5;
  localparam logic [3:0] OP_CLR_W     = 4'h6;
  localparam logic [3:0] OP_DEC_SKIP  = 4'h7;

  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE    = 1'b1;

  // Values after reset and fixed loads
  localparam logic [7:0]  WORK_RST      = 8'h00;
  localparam logic [14:0] PC_RST        = 15'h0000;
  localparam logic [6:0]  PLH_RST       = 7'h00;
  localparam logic [6:0]  FADDR_RST     = 7'h00;
  localparam logic        TIMEOUT_RST   = 1'b1;
  localparam logic        PD_RST        = 1'b1;
  localparam logic [7:0]  WDT_CLEAR_VAL = 8'h00;
  localparam logic [7:0]  CLEAR_VAL     = 8'h00;
  localparam logic [7:0]  DEC_STEP      = 8'h01;
  localparam logic [14:0] PC_STEP       = 15'h0001;

  // Watchdog prescaler division, file and stack depths
  localparam int unsigned WDT_PRESCALE  = 256;
  localparam int unsigned FILE_DEPTH    = 128;
  localparam int unsigned STACK_DEPTH   = 16;

  typedef enum logic {CCDO_IDLE, CCDO_FLUSH} ccdo_state_e;

endpackage

// [ccdo_watchdog.sv]
// Watchdog counter with prescaler and synchronous clear
`timescale 1ns/100ps
module ccdo_watchdog #(
  parameter int unsigned PRESCALE = ccdo_pkg::WDT_PRESCALE,
  parameter int unsigned CNT_W    = 8,
  parameter int unsigned PS_W     = $clog2(PRESCALE)
) (
  input  wire logic              clk,      // Core clock
  input  wire logic              rst_b,    // Sync reset, active low
  input  wire logic              clear,    // Restart counter and prescaler
  output logic [CNT_W-1:0]       count,    // Counter value
  output logic [PS_W-1:0]        prescale, // Prescaler value
  output logic                   expire    // Overflow pulse
);
  logic [CNT_W-1:0] next_count;
  logic [PS_W-1:0]  next_prescale;
  logic             tick;

  always_comb begin
    tick          = (prescale == PS_W'(PRESCALE - 1));
    next_prescale = tick ? '0 : PS_W'(prescale + 1'b1);
    next_count    = tick ? CNT_W'(count + 1'b1) : count;
    expire        = tick && (&count) && !clear;
    if (clear) begin
      next_prescale = '0;
      next_count    = CNT_W'(ccdo_pkg::WDT_CLEAR_VAL);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count    <= '0;
      prescale <= '0;
    end else begin
      count    <= next_count;
      prescale <= next_prescale;
    end
  end
endmodule
